// [rtl/ofsc_pkg.sv]
// Constants shared by the output freeze serial control block.
package ofsc_pkg;

    // Number of freezable outputs.
    localparam int NUM_OUTPUTS = 12;
    // Width of the bit counter.
    localparam int CNT_W = 4;
    // Index of the last enable bit.
    localparam logic [3:0] LAST_BIT = 4'hb;
    // Enables after reset: every output runs.
    localparam logic [11:0] ENABLE_RESET = 12'hfff;

    // Avalon-MM byte addresses.
    localparam int ADDR_W = 4;
    localparam logic [3:0] STATUS_ADDR = 4'h0;
    localparam logic [3:0] CONTROL_ADDR = 4'h4;
    localparam logic [3:0] FRAMES_ADDR = 4'h8;

    // Field positions.
    localparam int STATUS_BUSY_BIT = 16;
    localparam int CONTROL_RX_EN_BIT = 0;
    localparam logic CONTROL_RX_EN_RESET = 1'h1;

    // Serial receiver states.
    typedef enum logic [1:0] {
        OFSC_IDLE,
        OFSC_SHIFT,
        OFSC_APPLY
    } ofsc_state_t;

endpackage

// [rtl/ofsc_gate_if.sv]
// Interface carrying one output clock through its freeze gate.
`timescale 1ns/1ps
interface ofsc_gate_if;
    logic src_clk;
    logic run_req;
    logic gated_clk;

    // The gate side receives the clock and request.
    modport gate (
        input src_clk,
        input run_req,
        output gated_clk
    );

    // The owner drives the clock and request.
    modport owner (
        output src_clk,
        output run_req,
        input gated_clk
    );
endinterface

// [rtl/ofsc_gate.sv]
// Glitch-free freeze gate for one output clock.
`timescale 1ns/1ps
module ofsc_gate (
    // Reset.
    input wire logic reset_n_in,
    // Gated clock path.
    ofsc_gate_if.gate gif
);

    logic run_sync1_reg;
    logic run_sync2_reg;
    logic run_reg;
    logic run_at_rise_reg;

    ////////////////////////////////////////////////////////////////////////
    // Bring the request into the output clock domain.
    always_ff @(posedge gif.src_clk or negedge reset_n_in) begin
        if (!reset_n_in) begin
            run_sync1_reg <= 1'h1;
            run_sync2_reg <= 1'h1;
        end else begin
            run_sync1_reg <= gif.run_req;
            run_sync2_reg <= run_sync1_reg;
        end
    end

    // Change while low.
    // Updating on the falling edge keeps the gate steady while the clock is high.
    always_ff @(negedge gif.src_clk or negedge reset_n_in) begin
        if (!reset_n_in) begin
            run_reg <= 1'h1;
        end else begin
            run_reg <= run_sync2_reg;
        end
    end

    assign gif.gated_clk = gif.src_clk & run_reg;

    // Copy of the gate taken at each rising edge, so the high phase can be checked.
    always_ff @(posedge gif.src_clk or negedge reset_n_in) begin
        if (!reset_n_in) begin
            run_at_rise_reg <= 1'h1;
        end else begin
            run_at_rise_reg <= run_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks of the gate.
    property p_gate_follows;
        @(negedge gif.src_clk) disable iff (!reset_n_in)
            run_reg == $past(run_sync2_reg);
    endproperty
    a_gate_follows: assert property (p_gate_follows)
        else $error("Gate did not follow its synchronised request.");

    property p_gate_steady_high;
        @(negedge gif.src_clk) disable iff (!reset_n_in)
            run_reg == run_at_rise_reg;
    endproperty
    a_gate_steady_high: assert property (p_gate_steady_high)
        else $error("Gate changed while its clock was high.");

endmodule // ofsc_gate

// [rtl/ofsc_top.sv]
// Output freeze serial receiver, register slave and twelve gates.
`timescale 1ns/1ps
module ofsc_top (
    // Clock and reset.
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // Serial freeze link.
    input wire logic freeze_serial_clock_in,
    input wire logic freeze_serial_data_in,
    // Output clocks before and after gating, and two clocks that pass through ungated.
    input wire logic [11:0] src_clk_in,
    output logic [11:0] gated_clk_out,
    input wire logic bank_c_first_clk_in,
    input wire logic feedback_clk_in,
    output logic bank_c_first_output_out,
    output logic feedback_output_out,
    // Avalon-MM slave.
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out
);

    logic clk_sync1_reg;
    logic clk_sync2_reg;
    logic clk_sync3_reg;
    logic data_sync1_reg;
    logic data_sync2_reg;
    logic freeze_edge;
    ofsc_pkg::ofsc_state_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [11:0] shift_reg;
    logic [11:0] enable_reg;
    logic rx_en_reg;
    logic [15:0] frames_reg;
    logic wait_reg;
    logic [31:0] readdata_reg;
    logic bus_req;
    logic bus_write_take;

    ////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers for the link pins.
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            clk_sync1_reg <= 1'h0;
            clk_sync2_reg <= 1'h0;
            clk_sync3_reg <= 1'h0;
            data_sync1_reg <= 1'h1;
            data_sync2_reg <= 1'h1;
        end else begin
            clk_sync1_reg <= freeze_serial_clock_in;
            clk_sync2_reg <= clk_sync1_reg;
            clk_sync3_reg <= clk_sync2_reg;
            data_sync1_reg <= freeze_serial_data_in;
            data_sync2_reg <= data_sync1_reg;
        end
    end

    // Rising edge detect.
    // Data and clock share the same delay, so data is taken as it stood at the edge.
    assign freeze_edge = clk_sync2_reg & ~clk_sync3_reg & rx_en_reg;

    ////////////////////////////////////////////////////////////////////////
    // Frame sequencing.
    // The apply edge also samples the next start bit.
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg <= ofsc_pkg::OFSC_IDLE;
            bit_cnt_reg <= 4'h0;
        end else if (freeze_edge) begin
            case (state_reg)
                ofsc_pkg::OFSC_IDLE: begin
                    if (!data_sync2_reg) begin
                        state_reg <= ofsc_pkg::OFSC_SHIFT;
                    end
                    bit_cnt_reg <= 4'h0;
                end
                ofsc_pkg::OFSC_SHIFT: begin
                    if (bit_cnt_reg == ofsc_pkg::LAST_BIT) begin
                        state_reg <= ofsc_pkg::OFSC_APPLY;
                    end
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                end
                ofsc_pkg::OFSC_APPLY: begin
                    state_reg <= data_sync2_reg ? ofsc_pkg::OFSC_IDLE : ofsc_pkg::OFSC_SHIFT;
                    bit_cnt_reg <= 4'h0;
                end
                default: begin
                    state_reg <= ofsc_pkg::OFSC_IDLE;
                    bit_cnt_reg <= 4'h0;
                end
            endcase
        end
    end

    // Twelve-bit shift.
    // First bit received ends in the top position.
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            shift_reg <= 12'h000;
        end else if (freeze_edge && state_reg == ofsc_pkg::OFSC_SHIFT) begin
            shift_reg <= {shift_reg[10:0], data_sync2_reg};
        end
    end

    // Apply together.
    // Enables move only on the edge after the twelfth bit.
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            enable_reg <= ofsc_pkg::ENABLE_RESET;
            frames_reg <= 16'h0000;
        end else if (freeze_edge && state_reg == ofsc_pkg::OFSC_APPLY) begin
            enable_reg <= shift_reg;
            frames_reg <= frames_reg + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One freeze gate per freezable output.
    genvar gi;
    generate
        for (gi = 0; gi < ofsc_pkg::NUM_OUTPUTS; gi++) begin : g_gate
            ofsc_gate_if gif ();
            assign gif.src_clk = src_clk_in[gi];
            assign gif.run_req = enable_reg[gi];
            assign gated_clk_out[gi] = gif.gated_clk;
            ofsc_gate u_gate (
                .reset_n_in(reset_n_in),
                .gif(gif)
            );
        end
    endgenerate

    assign bank_c_first_output_out = bank_c_first_clk_in;
    assign feedback_output_out = feedback_clk_in;

    ////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave with one wait state per access.
    assign bus_req = avs_read_in | avs_write_in;
    assign bus_write_take = avs_write_in & ~wait_reg;

    // Wait state toggles low for exactly one cycle per request.
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wait_reg <= 1'h1;
        end else begin
            wait_reg <= ~(bus_req & wait_reg);
        end
    end

    // Read data is captured one cycle before the answer.
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            readdata_reg <= 32'h00000000;
        end else if (avs_read_in && wait_reg) begin
            case (avs_address_in)
                ofsc_pkg::STATUS_ADDR: begin
                    readdata_reg <= {15'h0000, state_reg != ofsc_pkg::OFSC_IDLE,
                                     4'h0, enable_reg};
                end
                ofsc_pkg::CONTROL_ADDR: begin
                    readdata_reg <= {31'h00000000, rx_en_reg};
                end
                ofsc_pkg::FRAMES_ADDR: begin
                    readdata_reg <= {16'h0000, frames_reg};
                end
                default: begin
                    readdata_reg <= 32'h00000000;
                end
            endcase
        end
    end

    // Receiver enable, written by software.
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rx_en_reg <= ofsc_pkg::CONTROL_RX_EN_RESET;
        end else if (bus_write_take && avs_address_in == ofsc_pkg::CONTROL_ADDR) begin
            rx_en_reg <= avs_writedata_in[ofsc_pkg::CONTROL_RX_EN_BIT];
        end
    end

    assign avs_waitrequest_out = wait_reg;
    assign avs_readdata_out = readdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks of the receiver, the ungated outputs and the bus wait state.
    property p_twelve_then_apply;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
            (freeze_edge && state_reg == ofsc_pkg::OFSC_SHIFT && bit_cnt_reg == 4'hb)
            |=> state_reg == ofsc_pkg::OFSC_APPLY;
    endproperty
    a_twelve_then_apply: assert property (p_twelve_then_apply)
        else $error("Receiver did not stop after twelve bits.");

    property p_sample_bit;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
            (freeze_edge && state_reg == ofsc_pkg::OFSC_SHIFT)
            |=> shift_reg[0] == $past(data_sync2_reg);
    endproperty
    a_sample_bit: assert property (p_sample_bit)
        else $error("Shift register missed the sampled bit.");

    property p_apply_value;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
            (freeze_edge && state_reg == ofsc_pkg::OFSC_APPLY)
            |=> enable_reg == $past(shift_reg);
    endproperty
    a_apply_value: assert property (p_apply_value)
        else $error("Applied enables differ from the received bits.");

    property p_apply_only_at_end;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
            $changed(enable_reg) |-> $past(freeze_edge && state_reg == ofsc_pkg::OFSC_APPLY);
    endproperty
    a_apply_only_at_end: assert property (p_apply_only_at_end)
        else $error("Enables changed while bits were arriving.");

    property p_restart;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
            (freeze_edge && state_reg == ofsc_pkg::OFSC_APPLY && !data_sync2_reg)
            |=> state_reg == ofsc_pkg::OFSC_SHIFT && bit_cnt_reg == 4'h0;
    endproperty
    a_restart: assert property (p_restart)
        else $error("Low bit after a frame did not start the next frame.");

    property p_idle_after;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
            (freeze_edge && state_reg != ofsc_pkg::OFSC_SHIFT && data_sync2_reg)
            |=> state_reg == ofsc_pkg::OFSC_IDLE;
    endproperty
    a_idle_after: assert property (p_idle_after)
        else $error("High bit outside a frame did not leave the receiver idle.");

    property p_fixed_outputs;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
            bank_c_first_output_out == bank_c_first_clk_in &&
            feedback_output_out == feedback_clk_in;
    endproperty
    a_fixed_outputs: assert property (p_fixed_outputs)
        else $error("An ungated output differs from its clock.");

    property p_one_wait;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
            (bus_req && wait_reg) |=> !wait_reg ##1 wait_reg;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("Bus answer not given after one wait state.");

    c_frame_applied: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        freeze_edge && state_reg == ofsc_pkg::OFSC_APPLY);
    c_back_to_back: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        freeze_edge && state_reg == ofsc_pkg::OFSC_APPLY && !data_sync2_reg);
    c_freeze_some: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        $fell(enable_reg[0]));

endmodule // ofsc_top

// [verification/ofsc_link_model.sv]
// Behavioural serial controller driving the freeze clock and data pins.
`timescale 1ns/1ps
module ofsc_link_model (
    // Serial freeze link.
    output logic freeze_serial_clock_out,
    output logic freeze_serial_data_out
);
    ////////////////////////////////////////////////////////////////////////////
    // The clock is parked low between frames and data rests high, so no start is seen.
    initial begin
        freeze_serial_clock_out = 1'b0;
        freeze_serial_data_out = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sends the low n bits of a word, the first bit taken from position n-1.
    task automatic send_bits(input logic [31:0] bits, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            freeze_serial_data_out = bits[i];
            #40 freeze_serial_clock_out = 1'b1;
            #80 freeze_serial_clock_out = 1'b0;
            #40;
        end
        freeze_serial_data_out = 1'b1;
    endtask
endmodule // ofsc_link_model

// [verification/tb_ofsc_top.sv]
// Self-checking testbench for the output freeze serial control block.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_ofsc_top;
    logic sys_clk_in, reset_n_in, freeze_serial_clock_in, freeze_serial_data_in;
    logic [11:0] src_clk_in, gated_clk_out, gprev;
    logic bank_c_first_clk_in, feedback_clk_in, bank_c_first_output_out, feedback_output_out;
    logic [3:0] avs_address_in;
    logic avs_read_in, avs_write_in, avs_waitrequest_out;
    logic [31:0] avs_writedata_in, avs_readdata_out, rd;
    int mismatches, compares;

    ofsc_top u_ofsc_top (.sys_clk_in, .reset_n_in, .freeze_serial_clock_in,
        .freeze_serial_data_in, .src_clk_in, .gated_clk_out, .bank_c_first_clk_in,
        .feedback_clk_in, .bank_c_first_output_out, .feedback_output_out, .avs_address_in,
        .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_readdata_out,
        .avs_waitrequest_out);
    ofsc_link_model u_ofsc_link_model (.freeze_serial_clock_out(freeze_serial_clock_in),
        .freeze_serial_data_out(freeze_serial_data_in));

    ////////////////////////////////////////////////////////////////////////////
    // System clock on 2.5 ns steps and the unrelated output clocks, their edges on whole nanoseconds.
    initial begin
        sys_clk_in = 1'b0;
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end
    for (genvar g = 0; g < 12; g++) begin : g_src
        initial begin
            src_clk_in[g] = 1'b0;
            forever #(10 + g) src_clk_in[g] = ~src_clk_in[g];
        end
    end
    initial begin
        bank_c_first_clk_in = 1'b0;
        forever #7 bank_c_first_clk_in = ~bank_c_first_clk_in;
    end
    initial begin
        feedback_clk_in = 1'b0;
        forever #9 feedback_clk_in = ~feedback_clk_in;
    end

    // Any edge of a gated output must land on the same edge of its source.
    always @(gated_clk_out) begin
        for (int i = 0; i < 12; i++)
            if (reset_n_in === 1'b1 && gated_clk_out[i] !== gprev[i])
                `CHK(gated_clk_out[i], src_clk_in[i])
        gprev = gated_clk_out;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // One Avalon-MM transfer, held until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                       output logic [31:0] q);
        int n;
        @(posedge sys_clk_in);
        avs_address_in <= a;
        avs_writedata_in <= wd;
        avs_write_in <= wr;
        avs_read_in <= ~wr;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk_in);
            if (avs_waitrequest_out === 1'b0) break;
        end
        if (n == 50) begin
            mismatches++;
            final_report();
        end
        q = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask

    // Expected status word from enables and busy flag.
    function automatic logic [31:0] st(input logic [11:0] en, input logic busy);
        return (32'(busy) << ofsc_pkg::STATUS_BUSY_BIT) | 32'(en);
    endfunction

    // Lets the gates settle, then compares each gated output against its enable and the two ungated outputs against their clocks.
    task automatic chk_gates(input logic [11:0] en);
        repeat (40) @(posedge sys_clk_in);
        repeat (20) begin
            @(posedge sys_clk_in);
            for (int i = 0; i < 12; i++)
                `CHK(gated_clk_out[i], en[i] ? src_clk_in[i] : 1'b0)
            `CHK({bank_c_first_output_out, feedback_output_out},
                {bank_c_first_clk_in, feedback_clk_in})
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        avs_address_in = 4'h0;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_writedata_in = 32'h0;
        gprev = 12'h000;
        mismatches = 0;
        compares = 0;
        reset_n_in = 1'b0;
        repeat (10) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        bus(1'b0, ofsc_pkg::STATUS_ADDR, 32'h0, rd);
        `CHK(rd, st(ofsc_pkg::ENABLE_RESET, 1'b0))
        bus(1'b0, ofsc_pkg::CONTROL_ADDR, 32'h0, rd);
        `CHK(rd, 32'h1)
        bus(1'b1, ofsc_pkg::STATUS_ADDR, 32'h0, rd);
        bus(1'b1, 4'hc, 32'hffff_ffff, rd);
        bus(1'b0, 4'hc, 32'h0, rd);
        `CHK(rd, 32'h0)
        bus(1'b0, ofsc_pkg::STATUS_ADDR, 32'h0, rd);
        `CHK(rd, st(12'hfff, 1'b0))
        chk_gates(12'hfff);
        $display("test reset done");
        fork
            u_ofsc_link_model.send_bits(32'({1'b0, 12'ha5c, 1'b1}), 14);
            begin
                #800;
                bus(1'b0, ofsc_pkg::STATUS_ADDR, 32'h0, rd);
                `CHK(rd, st(12'hfff, 1'b1))
            end
        join
        bus(1'b0, ofsc_pkg::STATUS_ADDR, 32'h0, rd);
        `CHK(rd, st(12'ha5c, 1'b0))
        chk_gates(12'ha5c);
        $display("test single frame done");
        u_ofsc_link_model.send_bits(32'({1'b0, 12'h3c6, 1'b0, 12'h000, 1'b1}), 27);
        bus(1'b0, ofsc_pkg::FRAMES_ADDR, 32'h0, rd);
        `CHK(rd, 32'h3)
        bus(1'b0, ofsc_pkg::STATUS_ADDR, 32'h0, rd);
        `CHK(rd, st(12'h000, 1'b0))
        chk_gates(12'h000);
        $display("test chained frames done");
        u_ofsc_link_model.send_bits(32'({3'b111, 1'b0, 12'hfff, 1'b1}), 17);
        bus(1'b0, ofsc_pkg::FRAMES_ADDR, 32'h0, rd);
        `CHK(rd, 32'h4)
        chk_gates(12'hfff);
        $display("test idle then frame done");
        bus(1'b1, ofsc_pkg::CONTROL_ADDR, 32'h0, rd);
        u_ofsc_link_model.send_bits(32'({1'b0, 12'h000, 1'b1}), 14);
        bus(1'b0, ofsc_pkg::STATUS_ADDR, 32'h0, rd);
        `CHK(rd, st(12'hfff, 1'b0))
        bus(1'b1, ofsc_pkg::CONTROL_ADDR, 32'h1, rd);
        bus(1'b0, ofsc_pkg::CONTROL_ADDR, 32'h0, rd);
        `CHK(rd, 32'h1)
        $display("test receiver disable done");
        u_ofsc_link_model.send_bits(32'({1'b0, 12'h000, 1'b1}), 14);
        chk_gates(12'h000);
        @(posedge sys_clk_in);
        reset_n_in <= 1'b0;
        repeat (10) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        bus(1'b0, ofsc_pkg::STATUS_ADDR, 32'h0, rd);
        `CHK(rd, st(ofsc_pkg::ENABLE_RESET, 1'b0))
        chk_gates(ofsc_pkg::ENABLE_RESET);
        $display("test reset in mid-run done");
        final_report();
    end
endmodule // tb_ofsc_top
